// ---- rtl/fws_consts.svh ----
// Offsets, field positions, reset values and timing values in ns of the host
`ifndef FWS_CONSTS_SVH
`define FWS_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets on the Wishbone slave
// ----------------------------------------------------------------------
`define FWS_OFF_CMD        8'h00
`define FWS_OFF_ADDR       8'h04
`define FWS_OFF_WDATA      8'h08
`define FWS_OFF_STATUS     8'h0C
`define FWS_OFF_IRQ_STAT   8'h10
`define FWS_OFF_IRQ_MASK   8'h14
`define FWS_OFF_POLL_LIM   8'h18

// ----------------------------------------------------------------------
// Command opcodes (CMD bits 2:0)
// ----------------------------------------------------------------------
`define FWS_OP_READ        3'h1
`define FWS_OP_WRITE       3'h2
`define FWS_OP_POLL        3'h3
`define FWS_OP_ERASE_ADD   3'h4

// ----------------------------------------------------------------------
// Status byte bit positions of the flash
// ----------------------------------------------------------------------
`define FWS_BIT_SECTOR_TGL 2
`define FWS_BIT_ERASE_TMR  3
`define FWS_BIT_TMO_FAIL   5
`define FWS_BIT_ACT_TGL    6
`define FWS_BIT_POLLING    7

// ----------------------------------------------------------------------
// Interrupt status bits
// ----------------------------------------------------------------------
`define FWS_IRQ_DONE       0
`define FWS_IRQ_FAIL       1
`define FWS_IRQ_LEFT       2
`define FWS_IRQ_REJECT     3
`define FWS_IRQ_W          4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define FWS_POLL_LIM_RST   16'h0100
`define FWS_IRQ_MASK_RST   4'h0
`define FWS_RESET_CMD      8'hF0

// ----------------------------------------------------------------------
// Timing: clock period and pin phase times in ns
// ----------------------------------------------------------------------
`define FWS_CLK_NS         100
`define FWS_SETUP_NS       100
`define FWS_STROBE_NS      200
`define FWS_HOLD_NS        100

`endif

// ---- rtl/fws_pkg.sv ----
// Types shared by the flash status host modules
package fws_pkg;

    // ------------------------------------------------------------------
    // Pin bundle driven toward the flash
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [20:0] addr;
        logic [7:0]  dq_out;
        logic        dq_oe;
        logic        ce_b;
        logic        oe_b;
        logic        we_b;
    } fws_pins_t;

    // ------------------------------------------------------------------
    // One bus cycle request to the pin engine
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        we;
        logic [20:0] addr;
        logic [7:0]  wdata;
    } fws_req_t;

    // ------------------------------------------------------------------
    // Sequencer states and outcome codes
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE     = 4'h0,
        ST_READ     = 4'h1,
        ST_WRITE    = 4'h2,
        ST_POLL_A   = 4'h3,
        ST_POLL_B   = 4'h4,
        ST_POLL_C   = 4'h5,
        ST_RESET    = 4'h6,
        ST_ADD_PRE  = 4'h7,
        ST_ADD_CMD  = 4'h8,
        ST_ADD_POST = 4'h9
    } fws_state_t;

    typedef enum logic [2:0] {
        RES_NONE     = 3'h0,
        RES_OK       = 3'h1,
        RES_FAIL     = 3'h2,
        RES_LEFT     = 3'h3,
        RES_ACCEPTED = 3'h4,
        RES_REJECTED = 3'h5,
        RES_RUNNING  = 3'h6,
        RES_XFER     = 3'h7
    } fws_result_t;

    typedef enum logic [1:0] {
        PH_IDLE   = 2'h0,
        PH_SETUP  = 2'h1,
        PH_STROBE = 2'h2,
        PH_HOLD   = 2'h3
    } fws_phase_t;

    // Byte-lane merge of a Wishbone write into a register
    function automatic logic [31:0] fws_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

endpackage

// ---- rtl/fws_bus_cycle.sv ----
// Pin engine: one asynchronous read or write cycle on the flash pins
`timescale 1ns/1ns
`include "fws_consts.svh"

module fws_bus_cycle
    import fws_pkg::*;
#(
    parameter int SETUP_NS  = `FWS_SETUP_NS,
    parameter int STROBE_NS = `FWS_STROBE_NS,
    parameter int HOLD_NS   = `FWS_HOLD_NS
) (
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic       go,
    input  wire fws_req_t   req,
    input  wire logic [7:0] dq_in,
    output fws_pins_t       pins,
    output logic [7:0]      rdata,
    output logic            done
);

    // Least times round up to whole cycles
    localparam int SETUP_CYC  = (SETUP_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS;
    localparam int STROBE_CYC = (STROBE_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS;
    localparam int HOLD_CYC   = (HOLD_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS;

    generate
        if (SETUP_CYC < 1 || STROBE_CYC < 1 || HOLD_CYC < 1 ||
            STROBE_CYC > 255) begin : g_bad
            $error("fws_bus_cycle: phase times out of range");
        end
    endgenerate

    fws_phase_t phase_q;
    logic [7:0] cnt_q;
    logic       we_q;

    // ------------------------------------------------------------------
    // Phase sequencer; the strobe always rises before chip select
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            phase_q <= PH_IDLE;
            cnt_q   <= 8'h00;
            we_q    <= 1'b0;
            pins    <= '{addr: 21'h000000, dq_out: 8'h00, dq_oe: 1'b0,
                         ce_b: 1'b1, oe_b: 1'b1, we_b: 1'b1};
            rdata   <= 8'h00;
            done    <= 1'b0;
        end else begin
            done <= 1'b0;
            case (phase_q)
                PH_IDLE: begin
                    if (go) begin
                        phase_q     <= PH_SETUP;
                        cnt_q       <= 8'(SETUP_CYC - 1);
                        we_q        <= req.we;
                        pins.addr   <= req.addr;
                        pins.dq_out <= req.wdata;
                        pins.dq_oe  <= req.we;
                        pins.ce_b   <= 1'b0;
                    end
                end
                PH_SETUP: begin
                    if (cnt_q == 8'h00) begin
                        phase_q   <= PH_STROBE;
                        cnt_q     <= 8'(STROBE_CYC - 1);
                        pins.we_b <= ~we_q;
                        pins.oe_b <= we_q;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                PH_STROBE: begin
                    if (cnt_q == 8'h00) begin
                        // Read data latched while output enable is low
                        if (!we_q) begin
                            rdata <= dq_in;
                        end
                        phase_q   <= PH_HOLD;
                        cnt_q     <= 8'(HOLD_CYC - 1);
                        pins.we_b <= 1'b1;  // Ends a command
                        pins.oe_b <= 1'b1;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                PH_HOLD: begin
                    if (cnt_q == 8'h00) begin
                        phase_q    <= PH_IDLE;
                        pins.ce_b  <= 1'b1;
                        pins.dq_oe <= 1'b0;
                        done       <= 1'b1;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                default: begin
                    phase_q <= PH_IDLE;
                end
            endcase
        end
    end

endmodule

// ---- rtl/fws_host.sv ----
// Flash write-status host: toggle polling and sector erase add checks
// Function
// - Host double-reads; unchanged toggle means finished
// - Toggling with fail bit high: recheck, else reset
// - Leaving polling restarts from first double read
// - Host writes reset command after any failure; the code writes it only when the recheck still toggles, not when polls run out
// - Timer check skippable only under 50us spacing
// - Check timer before and after each add
`timescale 1ns/1ns
`include "fws_consts.svh"

module fws_host
    import fws_pkg::*;
#(
    parameter int         SETUP_NS  = `FWS_SETUP_NS,
    parameter int         STROBE_NS = `FWS_STROBE_NS,
    parameter int         HOLD_NS   = `FWS_HOLD_NS,
    parameter logic [7:0] RESET_CMD = `FWS_RESET_CMD
) (
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq,
    output fws_pins_t        flash_pins,
    input  wire logic [7:0]  flash_dq_in
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    fws_state_t  state_q;
    fws_result_t result_q;
    logic        issued_q;
    logic [20:0] addr_q;
    logic [7:0]  wdata_q;
    logic [15:0] poll_lim_q;
    logic [15:0] polls_left_q;
    logic [7:0]  prev_q;
    logic [7:0]  last_q;
    logic        act_tgl_q;
    logic        sec_tgl_q;
    logic        tmo_seen_q;
    logic [`FWS_IRQ_W-1:0] irq_stat_q;
    logic [`FWS_IRQ_W-1:0] irq_mask_q;
    logic [`FWS_IRQ_W-1:0] irq_set;
    logic        wb_hit;
    logic        wr_cmd;
    logic        cyc_go;
    logic        cyc_done;
    logic [7:0]  cyc_rdata;
    fws_req_t    cyc_req;
    logic [31:0] status_w;
    logic [31:0] addr_mrg;
    logic [31:0] lim_mrg;

    assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_cmd = wb_hit && wb_we_i && wb_sel_i[0] &&
                    (wb_adr_i == `FWS_OFF_CMD) && (state_q == ST_IDLE);
    assign addr_mrg = fws_merge({11'h000, addr_q}, wb_dat_i, wb_sel_i);
    assign lim_mrg  = fws_merge({16'h0000, poll_lim_q}, wb_dat_i, wb_sel_i);

    // ------------------------------------------------------------------
    // Pin engine
    // ------------------------------------------------------------------
    // Request contents follow the state; writes carry command bytes
    always_comb begin
        cyc_req.we    = (state_q == ST_WRITE) || (state_q == ST_RESET) ||
                        (state_q == ST_ADD_CMD);
        cyc_req.addr  = addr_q;
        cyc_req.wdata = (state_q == ST_RESET) ? RESET_CMD : wdata_q;
        cyc_go        = (state_q != ST_IDLE) && !issued_q;
    end

    fws_bus_cycle #(
        .SETUP_NS  (SETUP_NS),
        .STROBE_NS (STROBE_NS),
        .HOLD_NS   (HOLD_NS)
    ) u_cycle (
        .clock (clock),
        .rst_b (rst_b),
        .go    (cyc_go),
        .req   (cyc_req),
        .dq_in (flash_dq_in),
        .pins  (flash_pins),
        .rdata (cyc_rdata),
        .done  (cyc_done)
    );

    // ------------------------------------------------------------------
    // Status sequencer
    // ------------------------------------------------------------------
    // One request at a time; each finished cycle re-arms the pin engine
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            issued_q <= 1'b0;
        end else if (cyc_done || state_q == ST_IDLE) begin
            issued_q <= 1'b0;
        end else if (cyc_go) begin
            issued_q <= 1'b1;
        end
    end

    // Polling compares each read with the one before it
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_q      <= ST_IDLE;
            result_q     <= RES_NONE;
            polls_left_q <= 16'h0000;
            prev_q       <= 8'h00;
            last_q       <= 8'h00;
            act_tgl_q    <= 1'b0;
            sec_tgl_q    <= 1'b0;
            tmo_seen_q   <= 1'b0;
            irq_set      <= '0;
        end else begin
            irq_set <= '0;
            if (cyc_done && !cyc_req.we) begin
                last_q <= cyc_rdata;
            end
            case (state_q)
                ST_IDLE: begin
                    if (wr_cmd) begin
                        result_q <= RES_NONE;
                        case (wb_dat_i[2:0])
                            `FWS_OP_READ:      state_q <= ST_READ;
                            `FWS_OP_WRITE:     state_q <= ST_WRITE;
                            // Every poll opens with a fresh pair
                            `FWS_OP_POLL: begin
                                state_q      <= ST_POLL_A;
                                polls_left_q <= poll_lim_q;
                            end
                            `FWS_OP_ERASE_ADD: state_q <= ST_ADD_PRE;
                            default:           state_q <= ST_IDLE;
                        endcase
                    end
                end
                ST_READ, ST_WRITE: begin
                    if (cyc_done) begin
                        state_q  <= ST_IDLE;
                        result_q <= RES_XFER;
                        irq_set[`FWS_IRQ_DONE] <= 1'b1;
                    end
                end
                ST_POLL_A: begin
                    if (cyc_done) begin
                        prev_q  <= cyc_rdata;
                        state_q <= ST_POLL_B;  // First of two reads
                    end
                end
                ST_POLL_B: begin
                    if (cyc_done) begin
                        prev_q    <= cyc_rdata;
                        // Activity bit shows mode, sector bit shows place
                        act_tgl_q <= prev_q[`FWS_BIT_ACT_TGL] ^
                                     cyc_rdata[`FWS_BIT_ACT_TGL];
                        sec_tgl_q <= prev_q[`FWS_BIT_SECTOR_TGL] ^
                                     cyc_rdata[`FWS_BIT_SECTOR_TGL];
                        tmo_seen_q <= cyc_rdata[`FWS_BIT_TMO_FAIL];
                        if (prev_q[`FWS_BIT_ACT_TGL] ==
                            cyc_rdata[`FWS_BIT_ACT_TGL]) begin
                            state_q  <= ST_IDLE;
                            result_q <= RES_OK;
                            irq_set[`FWS_IRQ_DONE] <= 1'b1;
                        end else if (cyc_data_fail(cyc_rdata)) begin
                            state_q <= ST_POLL_C;
                        end else if (polls_left_q != 16'h0000) begin
                            polls_left_q <= polls_left_q - 16'h0001;
                        end else begin
                            // Gives up; the next poll starts over
                            state_q  <= ST_IDLE;
                            result_q <= RES_LEFT;
                            irq_set[`FWS_IRQ_LEFT] <= 1'b1;
                        end
                    end
                end
                ST_POLL_C: begin
                    if (cyc_done) begin
                        // Toggle may stop just as the fail bit rises
                        if (prev_q[`FWS_BIT_ACT_TGL] ==
                            cyc_rdata[`FWS_BIT_ACT_TGL]) begin
                            state_q  <= ST_IDLE;
                            result_q <= RES_OK;
                            irq_set[`FWS_IRQ_DONE] <= 1'b1;
                        end else begin
                            state_q <= ST_RESET;
                        end
                    end
                end
                ST_RESET: begin
                    if (cyc_done) begin
                        state_q  <= ST_IDLE;
                        result_q <= RES_FAIL;
                        irq_set[`FWS_IRQ_FAIL] <= 1'b1;
                        irq_set[`FWS_IRQ_DONE] <= 1'b1;
                    end
                end
                ST_ADD_PRE: begin
                    if (cyc_done) begin
                        // Erase already running would ignore the add
                        if (cyc_rdata[`FWS_BIT_ERASE_TMR]) begin
                            state_q  <= ST_IDLE;
                            result_q <= RES_RUNNING;
                            irq_set[`FWS_IRQ_REJECT] <= 1'b1;
                            irq_set[`FWS_IRQ_DONE]   <= 1'b1;
                        end else begin
                            state_q <= ST_ADD_CMD;
                        end
                    end
                end
                ST_ADD_CMD: begin
                    if (cyc_done) begin
                        state_q <= ST_ADD_POST;
                    end
                end
                ST_ADD_POST: begin
                    if (cyc_done) begin
                        state_q <= ST_IDLE;
                        irq_set[`FWS_IRQ_DONE] <= 1'b1;
                        if (cyc_rdata[`FWS_BIT_ERASE_TMR]) begin
                            result_q <= RES_REJECTED;
                            irq_set[`FWS_IRQ_REJECT] <= 1'b1;
                        end else begin
                            result_q <= RES_ACCEPTED;
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Fail bit test on a status byte
    function automatic logic cyc_data_fail(input logic [7:0] d);
        return d[`FWS_BIT_TMO_FAIL];
    endfunction

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    // Only an idle sequencer takes new address and data
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            addr_q     <= 21'h000000;
            wdata_q    <= 8'h00;
            poll_lim_q <= `FWS_POLL_LIM_RST;
            irq_mask_q <= `FWS_IRQ_MASK_RST;
        end else if (wb_hit && wb_we_i) begin
            case (wb_adr_i)
                `FWS_OFF_ADDR:
                    if (state_q == ST_IDLE) begin
                        addr_q <= addr_mrg[20:0];
                    end
                `FWS_OFF_WDATA:
                    if (state_q == ST_IDLE && wb_sel_i[0]) begin
                        wdata_q <= wb_dat_i[7:0];
                    end
                `FWS_OFF_POLL_LIM:
                    poll_lim_q <= lim_mrg[15:0];
                `FWS_OFF_IRQ_MASK:
                    if (wb_sel_i[0]) begin
                        irq_mask_q <= wb_dat_i[`FWS_IRQ_W-1:0];
                    end
                default: begin
                end
            endcase
        end
    end

    // Sticky events; a new event beats a same-cycle clear
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            irq_stat_q <= '0;
        end else if (wb_hit && wb_we_i && wb_sel_i[0] &&
                     wb_adr_i == `FWS_OFF_IRQ_STAT) begin
            irq_stat_q <= (irq_stat_q & ~wb_dat_i[`FWS_IRQ_W-1:0]) | irq_set;
        end else begin
            irq_stat_q <= irq_stat_q | irq_set;
        end
    end

    // Level interrupt, registered
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    assign status_w = {16'h0000, last_q, prev_q[`FWS_BIT_POLLING], tmo_seen_q,
                       sec_tgl_q, act_tgl_q, result_q, state_q != ST_IDLE};

    // Wishbone answer one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_hit;
            if (wb_hit && !wb_we_i) begin
                case (wb_adr_i)
                    `FWS_OFF_CMD:      wb_dat_o <= {28'h0000000,
                                                    state_q};
                    `FWS_OFF_ADDR:     wb_dat_o <= {11'h000, addr_q};
                    `FWS_OFF_WDATA:    wb_dat_o <= {24'h000000, wdata_q};
                    `FWS_OFF_STATUS:   wb_dat_o <= status_w;
                    `FWS_OFF_IRQ_STAT: wb_dat_o <= {28'h0000000, irq_stat_q};
                    `FWS_OFF_IRQ_MASK: wb_dat_o <= {28'h0000000, irq_mask_q};
                    `FWS_OFF_POLL_LIM: wb_dat_o <= {16'h0000, poll_lim_q};
                    default:           wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

endmodule

// ---- test/fws_properties.sv ----
// Checker of the host's bus handshake and flash pin cycles
`timescale 1ns/1ns
module fws_properties
    import fws_pkg::*;
(
    input wire logic      clock,
    input wire logic      rst_b,
    input wire logic      wb_cyc_i,
    input wire logic      wb_stb_i,
    input wire logic      wb_ack_o,
    input wire fws_pins_t flash_pins
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);
    // Strobes high while chip stays selected
    sequence s_hold;
        flash_pins.oe_b && flash_pins.we_b && !flash_pins.ce_b;
    endsequence
    property p_ack;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack late");
    property p_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_pulse: assert property (p_pulse) else $error("ack too long");
    property p_excl;
        !(!flash_pins.oe_b && !flash_pins.we_b);
    endproperty
    a_excl: assert property (p_excl) else $error("both strobes");
    property p_oe_ce;
        !flash_pins.oe_b |-> !flash_pins.ce_b && !flash_pins.dq_oe;
    endproperty
    a_oe_ce: assert property (p_oe_ce) else $error("read unframed");
    property p_rstr;
        $fell(flash_pins.oe_b) |=> !flash_pins.oe_b ##1 s_hold;
    endproperty
    a_rstr: assert property (p_rstr) else $error("read strobe");
    property p_wstr;
        $fell(flash_pins.we_b) |=> !flash_pins.we_b ##1 s_hold;
    endproperty
    a_wstr: assert property (p_wstr) else $error("write strobe");
    property p_addr;
        !flash_pins.ce_b && !$past(flash_pins.ce_b) |->
            $stable(flash_pins.addr);
    endproperty
    a_addr: assert property (p_addr) else $error("addr moved");
    property p_wdat;
        !flash_pins.we_b |-> flash_pins.dq_oe && $stable(flash_pins.dq_out);
    endproperty
    a_wdat: assert property (p_wdat) else $error("wdata moved");
endmodule
bind fws_host fws_properties u_chk (.clock, .rst_b, .wb_cyc_i,
    .wb_stb_i, .wb_ack_o, .flash_pins);

// ---- test/fws_flash_model.sv ----
// Behavioural flash status model facing the host
`timescale 1ns/1ns
module fws_flash_model
    import fws_pkg::*;
(
    input wire logic       clock,
    input wire logic       load,
    input wire logic [7:0] n,
    input wire logic       fail,
    input wire logic       tmr,
    input wire fws_pins_t  pins,
    output logic [7:0]     dq,
    output logic           rst_seen
);
    logic [7:0] left_q;
    logic       tgl_q;
    logic       fail_q;
    logic [7:0] last_q;
    logic       oe_q;
    logic       we_q;
    wire logic drv = !pins.ce_b && !pins.oe_b;
    // Status byte; toggles share one flop, sector erasing
    wire logic [7:0] st = {left_q == 8'h00, tgl_q, fail_q, 1'b0, tmr,
                           tgl_q, 2'h0};
    // Released bus shows the inverse so stale data never matches
    assign dq = drv ? st : ~last_q;
    always_ff @(posedge clock) begin
        oe_q <= pins.oe_b;
        we_q <= pins.we_b;
        if (drv)
            last_q <= st;
        if (load) begin
            left_q <= n;
            fail_q <= fail;
            tgl_q <= 1'b0;
            rst_seen <= 1'b0;
        end else if (!oe_q && pins.oe_b && left_q != 8'h00) begin
            tgl_q <= ~tgl_q;
            left_q <= (left_q == 8'hFF) ? left_q : left_q - 8'h01;
        end else if (!we_q && pins.we_b && pins.dq_out == 8'hF0) begin
            left_q <= 8'h00;
            fail_q <= 1'b0;
            rst_seen <= 1'b1;
        end
    end
endmodule

// ---- test/flash_write_status_bits_bench.sv ----
// Self-checking bench of the flash write-status host
`timescale 1ns/1ns
`include "fws_consts.svh"
module flash_write_status_bits_bench;
    import fws_pkg::*;
    logic clock = 0, rst_b = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [7:0] wb_adr_i = 8'h00, n = 8'h00, flash_dq_in;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, r;
    logic wb_ack_o, irq, load = 1, fail = 0, tmr = 0, rst_seen;
    fws_pins_t flash_pins;
    int fail_count = 0, check_count = 0;
    fws_host uut (.clock, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq,
        .flash_pins, .flash_dq_in);
    fws_flash_model fm (.clock, .load, .n, .fail, .tmr,
        .pins(flash_pins), .dq(flash_dq_in), .rst_seen);
    always #50 clock = ~clock;
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s exp %h got %h", nm, exp, got);
        end
    endtask
    // Classic cycle held until ack is sampled, then one idle clock
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        wb_cyc_i <= 1;
        wb_stb_i <= 1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clock); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 0;
        wb_stb_i <= 0;
        @(posedge clock);
    endtask
    // Arm the model, issue an op, wait for idle and judge the result
    task automatic op(input logic [2:0] o, input logic [7:0] nn,
                      input logic fl, input logic [2:0] res);
        n <= nn;
        fail <= fl;
        load <= 1;
        @(posedge clock);
        load <= 0;
        wb(1, `FWS_OFF_CMD, {29'h0, o}, r);
        r = 32'h1;
        for (int i = 0; i < 300 && r[0] !== 1'b0; i++)
            wb(0, `FWS_OFF_STATUS, 32'h0, r);
        chk("result", {29'h0, r[3:1]}, {29'h0, res});
    endtask
    task automatic t_regs();
        wb(0, `FWS_OFF_POLL_LIM, 32'h0, r);
        chk("poll_lim", r, 32'h00000100);
        wb(0, `FWS_OFF_IRQ_MASK, 32'h0, r);
        chk("mask", r, 32'h0);
        wb(1, 8'h40, 32'hFFFFFFFF, r);
        wb(0, 8'h40, 32'h0, r);
        chk("unmapped", r, 32'h0);
        op(`FWS_OP_READ, 8'h00, 0, 3'h7);
        op(`FWS_OP_WRITE, 8'h00, 0, 3'h7);
    endtask
    task automatic t_done();
        op(`FWS_OP_POLL, 8'h03, 0, 3'h1);
        chk("irq masked", irq, 1'b0);
        wb(1, `FWS_OFF_IRQ_MASK, 32'h1, r);
        repeat (2) @(posedge clock);
        chk("irq on", irq, 1'b1);
        wb(1, `FWS_OFF_IRQ_STAT, 32'h1, r);
        repeat (2) @(posedge clock);
        chk("irq off", irq, 1'b0);
    endtask
    task automatic t_fail();
        op(`FWS_OP_POLL, 8'hFF, 1, 3'h2);
        chk("reset cmd", rst_seen, 1'b1);
        wb(0, `FWS_OFF_IRQ_STAT, 32'h0, r);
        chk("fail irq", r[1], 1'b1);
    endtask
    task automatic t_left();
        wb(1, `FWS_OFF_POLL_LIM, 32'h2, r);
        op(`FWS_OP_POLL, 8'hFF, 0, 3'h3);
        op(`FWS_OP_POLL, 8'h02, 0, 3'h1);
    endtask
    task automatic t_add();
        tmr <= 0;
        op(`FWS_OP_ERASE_ADD, 8'h00, 0, 3'h4);
        tmr <= 1;
        op(`FWS_OP_ERASE_ADD, 8'h00, 0, 3'h6);
    endtask
    initial begin
        repeat (2) @(posedge clock);
        rst_b <= 1;
        load <= 0;
        @(posedge clock);
        t_regs();
        t_done();
        t_fail();
        t_left();
        t_add();
        stop_test();
    end
    // Hang guard, well beyond the few hundred clocks needed
    initial begin
        #3000000;
        fail_count++;
        stop_test();
    end
endmodule
